// *** srmp_cfg.svh ***
// Constants for the burst-of-two common-I/O memory port.
// Assumes a 20 MHz system clock that samples the slower link clock pair.
`ifndef SRMP_CFG_SVH
`define SRMP_CFG_SVH

`define SRMP_DATA_W        36
`define SRMP_ADDR_W        20
`define SRMP_NBYTE         4
`define SRMP_BYTE_W        9
`define SRMP_PIPE_D        7
`define SRMP_BEAT0_DLL     5
`define SRMP_BEAT0_BYP     2
`define SRMP_SYS_PERIOD_NS 50
`define SRMP_KSTOP_NS      30
`define SRMP_KSTOP_CYC     ((`SRMP_KSTOP_NS + `SRMP_SYS_PERIOD_NS - 1) / `SRMP_SYS_PERIOD_NS)
`define SRMP_DLL_LOCK_CYC  12'd2048
`define SRMP_ZQ_CAL_CYC    11'd1024
`define SRMP_IMP_MID       4'h8
`define SRMP_IMP_FINAL     4'h5

`endif

// *** srmp_pkg.sv ***
// Types shared by the memory port.
// Assumes srmp_cfg.svh is on the include path.
`include "srmp_cfg.svh"
`default_nettype none

package srmp_pkg;

    // Pin bundle as sampled through the synchroniser
    typedef struct packed {
        logic                      k;
        logic                      k_n;
        logic                      load_n;
        logic                      rw;
        logic                      byp_n;
        logic [`SRMP_ADDR_W-1:0]   addr;
        logic [`SRMP_NBYTE-1:0]    bw_n;
        logic [`SRMP_DATA_W-1:0]   dq;
    } srmp_pin_t;

    // One buffered burst write
    typedef struct packed {
        logic                               valid;
        logic [`SRMP_ADDR_W-1:0]            addr;
        logic [1:0][`SRMP_DATA_W-1:0]       data;
        logic [1:0][`SRMP_NBYTE-1:0]        mask_n;
    } srmp_went_t;

    // One read in flight
    typedef struct packed {
        logic                      valid;
        logic [`SRMP_ADDR_W-1:0]   addr;
    } srmp_rslot_t;

    typedef enum logic [2:0] {
        DLL_LOCKING = 3'b001,
        DLL_LOCKED  = 3'b010,
        DLL_BYP     = 3'b100
    } srmp_dll_t;

    typedef enum logic [2:0] {
        WR_IDLE  = 3'b001,
        WR_BEAT0 = 3'b010,
        WR_BEAT1 = 3'b100
    } srmp_wr_t;

endpackage : srmp_pkg

`default_nettype wire

// *** srmp_port.sv ***
// Burst-of-two double-data-rate common-I/O static memory, device side.
// Assumes the controller's clock pair and pins are asynchronous to sys_clk
// and run well below a quarter of its rate.
//
// How it works
// R1: Every access is a two-beat burst
// R2: Read when select high at clock rise
// R3: First read beat two and half cycles later
// R4: Second read beat three cycles later
// R5: Free-running echo clocks aligned with data
// R6: Load strobe low registers address and direction
// R7: Idle cycle keeps reads, drivers then release
// R8: Writes accepted every other clock rise
// R9: Controller releases bus one cycle before writing
// R10: Write beats one cycle after command, then inverted
// R11: Buffered writes commit on third write
// R12: Reads see pending and newest write data
// R13: Active-low byte masks sampled with beats
// R14: Read cycles never write the array
// R15: Impedance calibrated within 1024 clock cycles
// R16: Read-valid rises half cycle early, falls one cycle early
// R17: Bypass pin low gives one-cycle latency
// R18: Bypass rise or clock stop resets loop
// R19: Lock after 2048 stable clock cycles
// R20: Controller resets loop at power-up, frequency change
// R21: Select high reads, low writes loaded address
// R22: Second beat uses address plus one
// R23: One mask per nine-bit data byte
`default_nettype none

module srmp_port
    import srmp_pkg::*;
(
    // System
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    input  wire logic                      clk_en,
    // Controller pins
    input  wire logic                      k,
    input  wire logic                      k_n,
    input  wire logic                      load_strobe_n,
    input  wire logic                      read_write_sel,
    input  wire logic                      dll_bypass_n,
    input  wire logic [`SRMP_ADDR_W-1:0]   sync_address,
    input  wire logic [`SRMP_NBYTE-1:0]    byte_write_mask_n,
    // Common data bus
    input  wire logic [`SRMP_DATA_W-1:0]   dq_in,
    output logic      [`SRMP_DATA_W-1:0]   dq_out,
    output logic                           dq_oe_n,
    // Echo and status
    output logic                           echo_clock,
    output logic                           echo_clock_inv,
    output logic                           read_valid_flag,
    output logic                           dll_locked,
    output logic                           impedance_calibrated,
    output logic      [3:0]                drive_impedance_code
);

    localparam int DW = `SRMP_DATA_W;
    localparam int AW = `SRMP_ADDR_W;
    localparam int PD = `SRMP_PIPE_D;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    // Data rides the same three stages as the clocks, so it lines up
    // with the edge that the third stage confirms.
    srmp_pin_t pin_raw, s1_q, s2_q, s3_q;
    logic      k_lvl_q, kn_lvl_q, byp_lvl_q;

    assign pin_raw = '{k: k, k_n: k_n, load_n: load_strobe_n, rw: read_write_sel,
                       byp_n: dll_bypass_n, addr: sync_address,
                       bw_n: byte_write_mask_n, dq: dq_in};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q      <= '0;
            s2_q      <= '0;
            s3_q      <= '0;
            k_lvl_q   <= 1'b0;
            kn_lvl_q  <= 1'b0;
            byp_lvl_q <= 1'b0;
        end else if (clk_en) begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q.k == s3_q.k) k_lvl_q <= s3_q.k;
            if (s2_q.k_n == s3_q.k_n) kn_lvl_q <= s3_q.k_n;
            if (s2_q.byp_n == s3_q.byp_n) byp_lvl_q <= s3_q.byp_n;
        end
    end

    logic k_rise, kn_rise, k_chg, byp_rise, hstep;
    assign k_rise   = s2_q.k & s3_q.k & ~k_lvl_q;
    assign kn_rise  = s2_q.k_n & s3_q.k_n & ~kn_lvl_q;
    assign k_chg    = (s2_q.k == s3_q.k) && (s3_q.k != k_lvl_q);
    assign byp_rise = s2_q.byp_n & s3_q.byp_n & ~byp_lvl_q;
    assign hstep    = k_rise | kn_rise;

    // ------------------------------------------------------------
    // Loop lock, clock-stop detect and impedance calibration
    // ------------------------------------------------------------
    srmp_dll_t   dll_st_q, dll_st_d;
    logic [11:0] lock_cnt_q, lock_cnt_d;
    logic [9:0]  idle_q, idle_d, half_q, half_d;
    logic [10:0] zq_cnt_q, zq_cnt_d;
    logic        kstop, ready;

    // Stopped means no edge for a measured half period plus the stop time
    assign kstop = (half_q != 10'd0) && (idle_q > half_q + 10'(`SRMP_KSTOP_CYC));
    assign ready = (dll_st_q == DLL_LOCKED) || (dll_st_q == DLL_BYP);

    always_comb begin
        dll_st_d   = dll_st_q;
        lock_cnt_d = lock_cnt_q;
        idle_d     = (idle_q == 10'h3ff) ? idle_q : idle_q + 10'd1;
        half_d     = half_q;
        zq_cnt_d   = zq_cnt_q;
        if (k_chg) begin
            idle_d = 10'd0;
            half_d = idle_q;
        end
        if (k_rise && zq_cnt_q != `SRMP_ZQ_CAL_CYC) zq_cnt_d = zq_cnt_q + 11'd1;  // R15
        // The rise is seen while the level is still low, so it must win over bypass
        if (byp_rise || (byp_lvl_q && kstop)) begin
            dll_st_d   = DLL_LOCKING;  // R18 R20
            lock_cnt_d = 12'd0;
        end else if (!byp_lvl_q) begin
            dll_st_d = DLL_BYP;  // R17
        end else if (dll_st_q == DLL_LOCKING && k_rise) begin
            lock_cnt_d = lock_cnt_q + 12'd1;
            if (lock_cnt_q == `SRMP_DLL_LOCK_CYC - 12'd1) dll_st_d = DLL_LOCKED;  // R19
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dll_st_q   <= DLL_LOCKING;
            lock_cnt_q <= 12'd0;
            idle_q     <= 10'd0;
            half_q     <= 10'd0;
            zq_cnt_q   <= 11'd0;
        end else if (clk_en) begin
            dll_st_q   <= dll_st_d;
            lock_cnt_q <= lock_cnt_d;
            idle_q     <= idle_d;
            half_q     <= half_d;
            zq_cnt_q   <= zq_cnt_d;
        end
    end

    assign dll_locked           = (dll_st_q == DLL_LOCKED);
    assign impedance_calibrated = (zq_cnt_q == `SRMP_ZQ_CAL_CYC);
    assign drive_impedance_code = impedance_calibrated ? `SRMP_IMP_FINAL : `SRMP_IMP_MID;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic cmd, rd_cmd, wr_cmd, wr_prev_q;
    assign cmd    = ready && k_rise && !s3_q.load_n;  // R6
    assign rd_cmd = cmd && s3_q.rw;  // R2 R21
    assign wr_cmd = cmd && !s3_q.rw && !wr_prev_q;  // R8 R21

    // ------------------------------------------------------------
    // Write path and coherency buffers
    // ------------------------------------------------------------
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] base,
                                            input logic [DW-1:0] data,
                                            input logic [`SRMP_NBYTE-1:0] mask_n);
        logic [DW-1:0] r;
        r = base;
        for (int b = 0; b < `SRMP_NBYTE; b++) begin
            if (!mask_n[b]) r[b*`SRMP_BYTE_W +: `SRMP_BYTE_W] = data[b*`SRMP_BYTE_W +: `SRMP_BYTE_W];  // R13 R23
        end
        return r;
    endfunction : merge

    function automatic logic [DW-1:0] fwd(input logic [DW-1:0] base, input srmp_went_t e,
                                          input logic [AW:0] wa);
        if (e.valid && e.addr == wa[AW:1]) return merge(base, e.data[wa[0]], e.mask_n[wa[0]]);
        return base;
    endfunction : fwd

    logic [DW-1:0] mem_q [0:(2**(AW+1))-1];
    srmp_wr_t      wr_st_q, wr_st_d;
    srmp_went_t    cur_q, cur_d, buf0_q, buf0_d, buf1_q, buf1_d;
    logic [AW-1:0] pend_addr_q, pend_addr_d;
    logic          pend_q, pend_d, wr_prev_d, mem_we;

    always_comb begin
        wr_st_d     = wr_st_q;
        cur_d       = cur_q;
        buf0_d      = buf0_q;
        buf1_d      = buf1_q;
        pend_d      = pend_q;
        pend_addr_d = pend_addr_q;
        mem_we      = 1'b0;
        wr_prev_d   = k_rise ? wr_cmd : wr_prev_q;
        if (wr_cmd && wr_st_q == WR_IDLE) begin
            wr_st_d = WR_BEAT0;
            cur_d   = '{valid: 1'b1, addr: s3_q.addr, data: '0, mask_n: '1};
        end else if (wr_cmd) begin
            pend_d      = 1'b1;
            pend_addr_d = s3_q.addr;
        end
        if (wr_st_q == WR_BEAT0 && k_rise) begin
            cur_d.data[0]   = s3_q.dq;  // R10 R13
            cur_d.mask_n[0] = s3_q.bw_n;
            wr_st_d         = WR_BEAT1;
        end else if (wr_st_q == WR_BEAT1 && kn_rise) begin
            cur_d.data[1]   = s3_q.dq;  // R10 R13
            cur_d.mask_n[1] = s3_q.bw_n;
            mem_we          = buf1_q.valid;  // R11 R14
            buf1_d          = buf0_q;
            buf0_d          = cur_d;
            wr_st_d         = pend_q ? WR_BEAT0 : WR_IDLE;
            cur_d           = pend_q ? '{valid: 1'b1, addr: pend_addr_q, data: '0, mask_n: '1}
                                     : '0;
            pend_d          = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_st_q     <= WR_IDLE;
            cur_q       <= '0;
            buf0_q      <= '0;
            buf1_q      <= '0;
            pend_q      <= 1'b0;
            pend_addr_q <= '0;
            wr_prev_q   <= 1'b0;
        end else if (clk_en) begin
            wr_st_q     <= wr_st_d;
            cur_q       <= cur_d;
            buf0_q      <= buf0_d;
            buf1_q      <= buf1_d;
            pend_q      <= pend_d;
            pend_addr_q <= pend_addr_d;
            wr_prev_q   <= wr_prev_d;
        end
    end

    // The array has no reset; only committed bursts ever land in it
    always_ff @(posedge sys_clk) begin
        if (clk_en && mem_we) begin
            mem_q[{buf1_q.addr, 1'b0}] <= merge(mem_q[{buf1_q.addr, 1'b0}], buf1_q.data[0],
                                                buf1_q.mask_n[0]);  // R11 R22
            mem_q[{buf1_q.addr, 1'b1}] <= merge(mem_q[{buf1_q.addr, 1'b1}], buf1_q.data[1],
                                                buf1_q.mask_n[1]);
        end
    end

    // ------------------------------------------------------------
    // Read pipeline, data drivers, echo clocks and valid flag
    // ------------------------------------------------------------
    srmp_rslot_t   pipe_q [PD];
    srmp_rslot_t   pipe_d [PD];
    logic [DW-1:0] dq_d, rd_word;
    logic [AW:0]   rd_wa;
    logic          oe_n_d, echo_d, read_valid_flag_d, beat0, beat1;
    int            b0;

    always_comb begin
        b0 = (dll_st_q == DLL_BYP) ? `SRMP_BEAT0_BYP : `SRMP_BEAT0_DLL;  // R17
        for (int i = 0; i < PD; i++) pipe_d[i] = pipe_q[i];
        if (hstep) begin
            pipe_d[0] = '{valid: rd_cmd, addr: s3_q.addr};  // R7
            for (int i = 1; i < PD; i++) pipe_d[i] = pipe_q[i-1];
        end
        beat0 = hstep && pipe_d[b0].valid;  // R3
        beat1 = hstep && pipe_d[b0+1].valid;  // R4
        rd_wa = beat1 ? {pipe_d[b0+1].addr, 1'b1} : {pipe_d[b0].addr, 1'b0};  // R1 R22
        // Oldest buffer first so the newest bytes win; buf1 also covers a same-cycle commit
        rd_word = fwd(fwd(fwd(mem_q[rd_wa], buf1_q, rd_wa), buf0_q, rd_wa), cur_d, rd_wa);  // R12
        dq_d    = (beat0 || beat1) ? rd_word : dq_out;
        oe_n_d  = hstep ? !(beat0 || beat1) : dq_oe_n;  // R7
        echo_d  = k_rise ? 1'b1 : (kn_rise ? 1'b0 : echo_clock);  // R5
        read_valid_flag_d  = hstep ? (pipe_d[b0-1].valid || (pipe_d[b0].valid && pipe_d[b0-2].valid))
                        : read_valid_flag;  // R16
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < PD; i++) pipe_q[i] <= '0;
            dq_out          <= '0;
            dq_oe_n         <= 1'b1;
            echo_clock      <= 1'b0;
            read_valid_flag <= 1'b0;
        end else if (clk_en) begin
            for (int i = 0; i < PD; i++) pipe_q[i] <= pipe_d[i];
            dq_out          <= dq_d;
            dq_oe_n         <= oe_n_d;
            echo_clock      <= echo_d;
            read_valid_flag <= read_valid_flag_d;
        end
    end

    assign echo_clock_inv = ~echo_clock;  // R5

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n || !clk_en);

    sequence s_read_taken;
        rd_cmd;
    endsequence

    sequence s_write_beat0;
        wr_st_q == WR_BEAT0 && k_rise;
    endsequence

    read_issue_a: assert property (s_read_taken |=> pipe_q[0].valid &&  // R2
        pipe_q[0].addr == $past(s3_q.addr)) else $error("read not entered in pipeline");
    nop_read_a: assert property (k_rise && s3_q.load_n |=> !pipe_q[0].valid)  // R7
        else $error("idle cycle started a read");
    beat_drive_a: assert property ($rose(pipe_q[`SRMP_BEAT0_DLL].valid) &&  // R3
        dll_st_q == DLL_LOCKED |-> !dq_oe_n) else $error("first beat not driven");
    write_gap_a: assert property (wr_cmd |=> !wr_cmd [*8])  // R8
        else $error("writes on adjacent edges");
    late_write_a: assert property (s_write_beat0 |=> wr_st_q == WR_BEAT1 &&  // R10
        cur_q.data[0] == $past(s3_q.dq)) else $error("first write beat not captured");
    commit_third_a: assert property (mem_we |-> buf0_q.valid && buf1_q.valid &&  // R11
        wr_st_q == WR_BEAT1) else $error("commit without two buffered writes");
    read_nowrite_a: assert property (rd_cmd && wr_st_q == WR_IDLE |=>  // R14
        wr_st_q == WR_IDLE && !pend_q)
        else $error("read cycle wrote array");
    zq_cal_a: assert property (k_rise && zq_cnt_q == `SRMP_ZQ_CAL_CYC - 11'd1 |=>  // R15
        drive_impedance_code == `SRMP_IMP_FINAL) else $error("impedance not final in time");
    echo_rise_a: assert property (k_rise |=> echo_clock && !echo_clock_inv)  // R5
        else $error("echo clock not following clock");
    read_valid_flag_early_a: assert property (hstep && pipe_d[b0-1].valid |=> read_valid_flag)  // R16
        else $error("read valid late");
    bypass_mode_a: assert property (!byp_lvl_q && !byp_rise |=> dll_st_q == DLL_BYP)  // R17
        else $error("bypass not entered");
    dll_reset_a: assert property (byp_rise |=> dll_st_q == DLL_LOCKING &&  // R18
        lock_cnt_q == 12'd0) else $error("loop not reset");
    lock_wait_a: assert property ($rose(dll_locked) |->  // R19
        lock_cnt_q == `SRMP_DLL_LOCK_CYC && $past(dll_st_q) == DLL_LOCKING)
        else $error("lock before full count");

endmodule : srmp_port

`default_nettype wire

// *** srmp_ctl.sv ***
// Controller model: clock pair, command pins and write data for the port.
// Assumes one task runs at a time; the bench owns reset and the bypass pin.
`include "srmp_cfg.svh"
`default_nettype none
module srmp_ctl
    import srmp_pkg::*;
(
    // Clocks
    input  wire logic                      sys_clk,
    output logic                           k,
    output logic                           k_n,
    // Commands
    output logic                           load_strobe_n,
    output logic                           read_write_sel,
    output logic      [`SRMP_ADDR_W-1:0]   sync_address,
    output logic      [`SRMP_NBYTE-1:0]    byte_write_mask_n,
    // Data
    output logic      [`SRMP_DATA_W-1:0]   dq_drv,
    output logic                           dq_en
);
    timeunit 1ns;
    timeprecision 1ps;

    logic run;

    // ----------------------------------------------------------------
    // Clock pair
    // ----------------------------------------------------------------
    // Odd offset keeps k edges away from system clock edges
    initial begin
        run = 1'b1;
        k = 1'b0;
        k_n = 1'b1;
        load_strobe_n = 1'b1;
        read_write_sel = 1'b1;
        sync_address = 20'h0;
        byte_write_mask_n = 4'hf;
        dq_drv = 36'h0;
        dq_en = 1'b0;
        #37;
        forever begin
            #200;
            if (run) begin
                k = ~k;
                k_n = ~k_n;
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus cycles
    // ----------------------------------------------------------------
    // Pins move two system cycles after an edge, clear of the sampling point
    task automatic hs(input logic on_k);
        if (on_k) @(posedge k);
        else @(posedge k_n);
        repeat (2) @(negedge sys_clk);
    endtask : hs

    // Both clocks held still resets the loop
    task automatic stop_clock(input int ns);
        run = 1'b0;
        #(ns);
        run = 1'b1;
    endtask : stop_clock

    task automatic issue_read(input logic [`SRMP_ADDR_W-1:0] a, output time t0);
        hs(1'b0);
        load_strobe_n = 1'b0;
        read_write_sel = 1'b1;
        sync_address = a;
        @(posedge k);
        t0 = $time;
        repeat (2) @(negedge sys_clk);
        load_strobe_n = 1'b1;
    endtask : issue_read

    // dbl puts a second write command on the very next k rise
    task automatic write_burst(input logic [`SRMP_ADDR_W-1:0] a,
                               input logic [`SRMP_DATA_W-1:0] d0, d1,
                               input logic [3:0] m0, m1, input logic dbl,
                               input logic [`SRMP_ADDR_W-1:0] a2);
        hs(1'b0);
        load_strobe_n = 1'b0;
        read_write_sel = 1'b0;
        sync_address = a;
        hs(1'b1);
        load_strobe_n = !dbl;
        sync_address = a2;
        dq_drv = d0;
        dq_en = 1'b1;
        byte_write_mask_n = m0;
        hs(1'b0);
        hs(1'b1);
        load_strobe_n = 1'b1;
        read_write_sel = 1'b1;
        dq_drv = d1;
        byte_write_mask_n = m1;
        hs(1'b0);
        // Released bus shows no stale value
        dq_drv = ~dq_drv;
        dq_en = 1'b0;
        byte_write_mask_n = 4'hf;
    endtask : write_burst
endmodule : srmp_ctl
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the memory port: bypass, calibration, lock, buffering.
// Assumes srmp_ctl drives the controller pins and the bus is shared through dq_in.
`include "srmp_cfg.svh"
`default_nettype none
module tb
    import srmp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                      sys_clk, rst_n, dll_bypass_n, k, k_n;
    logic                      load_strobe_n, read_write_sel, dq_en, dq_oe_n;
    logic                      echo_clock, echo_clock_inv, read_valid_flag;
    logic                      dll_locked, impedance_calibrated;
    logic [3:0]                drive_impedance_code, byte_write_mask_n;
    logic [`SRMP_ADDR_W-1:0]   sync_address;
    logic [`SRMP_DATA_W-1:0]   dq_in, dq_out, dq_drv;
    logic [`SRMP_DATA_W-1:0]   exp_mem [logic [`SRMP_ADDR_W:0]];
    int                        err_total, checks_done, k_rises;
    int                        cyc = 0;

    assign dq_in = (dq_oe_n === 1'b0) ? dq_out : dq_drv;

    // Device and controller never drive the bus together
    always @(negedge sys_clk) if (rst_n && dq_en) chk_b(dq_oe_n, 1'b1);

    srmp_port srmp_port_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .k(k), .k_n(k_n),
        .load_strobe_n(load_strobe_n), .read_write_sel(read_write_sel),
        .dll_bypass_n(dll_bypass_n), .sync_address(sync_address),
        .byte_write_mask_n(byte_write_mask_n), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .echo_clock(echo_clock), .echo_clock_inv(echo_clock_inv),
        .read_valid_flag(read_valid_flag), .dll_locked(dll_locked),
        .impedance_calibrated(impedance_calibrated),
        .drive_impedance_code(drive_impedance_code));
    srmp_ctl srmp_ctl_i (
        .sys_clk(sys_clk), .k(k), .k_n(k_n), .load_strobe_n(load_strobe_n),
        .read_write_sel(read_write_sel), .sync_address(sync_address),
        .byte_write_mask_n(byte_write_mask_n), .dq_drv(dq_drv), .dq_en(dq_en));

    // ----------------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------------
    task automatic chk_w(input logic [`SRMP_DATA_W-1:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_w

    task automatic chk_b(input logic got, exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_b

    task automatic summarize();
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    function automatic logic [35:0] merge(input logic [35:0] old, nw, input logic [3:0] m);
        merge = old;
        for (int i = 0; i < 4; i++) if (!m[i]) merge[i*9 +: 9] = nw[i*9 +: 9];
    endfunction : merge

    // Outputs trail the pins by up to four cycles, so sample 80 ns into the next half-step
    task automatic at_step(input time t0, input int s);
        #(t0 + 200 * s + 280 - $time);
        chk_b(echo_clock, !s[0]);
        chk_b(echo_clock_inv, s[0]);
    endtask : at_step

    task automatic rd(input logic [`SRMP_ADDR_W-1:0] a, input int b);
        time t0;
        srmp_ctl_i.issue_read(a, t0);
        at_step(t0, b - 1);
        chk_b(dq_oe_n, 1'b1);
        chk_b(read_valid_flag, 1'b1);
        at_step(t0, b);
        chk_b(dq_oe_n, 1'b0);
        chk_b(read_valid_flag, 1'b0);
        chk_w(dq_out, exp_mem[{a, 1'b0}]);
        at_step(t0, b + 1);
        chk_b(dq_oe_n, 1'b0);
        chk_w(dq_out, exp_mem[{a, 1'b1}]);
        at_step(t0, b + 2);
        chk_b(dq_oe_n, 1'b1);
    endtask : rd

    task automatic wr(input logic [`SRMP_ADDR_W-1:0] a, input logic [7:0] tg,
                      input logic [3:0] m0, m1, input logic dbl = 1'b0,
                      input logic [`SRMP_ADDR_W-1:0] a2 = 20'h0);
        logic [35:0] d0, d1;
        d0 = {tg, 8'h3c, a};
        d1 = {~tg, 8'hc3, a};
        srmp_ctl_i.write_burst(a, d0, d1, m0, m1, dbl, a2);
        exp_mem[{a, 1'b0}] = merge(exp_mem[{a, 1'b0}], d0, m0);
        exp_mem[{a, 1'b1}] = merge(exp_mem[{a, 1'b1}], d1, m1);
    endtask : wr

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_impedance();
        wait (k_rises >= 1016);
        chk_b(impedance_calibrated, 1'b0);
        chk_w({32'h0, drive_impedance_code}, {32'h0, `SRMP_IMP_MID});
        wait (k_rises >= 1032);
        chk_b(impedance_calibrated, 1'b1);
        chk_w({32'h0, drive_impedance_code}, {32'h0, `SRMP_IMP_FINAL});
    endtask : t_impedance

    task automatic t_lock();
        int n0;
        @(negedge sys_clk);
        dll_bypass_n = 1'b1;
        n0 = k_rises;
        wait (k_rises >= n0 + 2040);
        chk_b(dll_locked, 1'b0);
        wait (k_rises >= n0 + 2064);
        chk_b(dll_locked, 1'b1);
    endtask : t_lock

    // Oldest entries commit, newest stay buffered, masked bytes keep old data
    task automatic t_buffer();
        wr(20'h00100, 8'h11, 4'h0, 4'h0);
        wr(20'h00200, 8'h22, 4'h0, 4'h0);
        wr(20'h00300, 8'h33, 4'h0, 4'h0);
        wr(20'h00100, 8'h99, 4'ha, 4'h5);
        rd(20'h00100, `SRMP_BEAT0_DLL);
        rd(20'h00200, `SRMP_BEAT0_DLL);
        rd(20'h00300, `SRMP_BEAT0_DLL);
        rd(20'h00100, `SRMP_BEAT0_DLL);
    endtask : t_buffer

    // A write command on the k rise right after a write is ignored
    task automatic t_refused();
        wr(20'h00400, 8'h44, 4'h0, 4'h0);
        wr(20'h00500, 8'h55, 4'h0, 4'h0, 1'b1, 20'h00400);
        wr(20'h00600, 8'h66, 4'h0, 4'h0);
        wr(20'h00700, 8'h77, 4'h0, 4'h0);
        rd(20'h00400, `SRMP_BEAT0_DLL);
        rd(20'h00500, `SRMP_BEAT0_DLL);
    endtask : t_refused

    // ----------------------------------------------------------------
    // Clock, reset and main sequence
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge k or negedge rst_n) begin
        if (!rst_n) k_rises <= 0;
        else k_rises <= k_rises + 1;
    end

    // Whole run is about 25000 cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 45000) begin
            err_total++;
            summarize();
        end
    end

    initial begin
        rst_n = 1'b0;
        dll_bypass_n = 1'b0;
        repeat (5) @(negedge sys_clk);
        chk_b(dq_oe_n, 1'b1);
        chk_b(echo_clock_inv, 1'b1);
        chk_b(read_valid_flag, 1'b0);
        chk_b(dll_locked, 1'b0);
        chk_b(impedance_calibrated, 1'b0);
        rst_n = 1'b1;
        repeat (8) @(posedge k);
        wr(20'h00010, 8'h5a, 4'h0, 4'h0);
        rd(20'h00010, `SRMP_BEAT0_BYP);
        t_impedance();
        t_lock();
        t_buffer();
        t_refused();
        srmp_ctl_i.stop_clock(600);
        repeat (4) @(negedge sys_clk);
        chk_b(dll_locked, 1'b0);
        summarize();
    end
endmodule : tb
`default_nettype wire
